// ==== hdl/cab_exec.sv ====
// Execution unit for add, shift, bit and relative jump instructions
module cab_exec
  import cab_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Instruction issue
  input wire logic issue_i,
  input wire cab_instr_t instr_i,
  output logic ready_o,
  // Architectural state and no-op/done status
  output logic [CAB_DATA_W-1:0] acc_o,
  output cab_flags_t flags_o,
  output logic [CAB_PC_W-1:0] pc_o,
  output logic nop_cycle_o,
  output logic done_o,
  // Host access to the file
  input wire logic host_we_i,
  input wire logic [CAB_ADDR_W-1:0] host_addr_i,
  input wire logic [CAB_DATA_W-1:0] host_wdata_i,
  output logic [CAB_DATA_W-1:0] host_rdata_o
);
  typedef enum logic [1:0] {
    CAB_ST_IDLE,
    CAB_ST_EXEC,
    CAB_ST_NOP
  } cab_state_t;

  cab_state_t state;
  cab_state_t next_state;
  cab_instr_t cur;
  logic [CAB_DATA_W-1:0] fval;
  logic [CAB_DATA_W-1:0] next_result;
  cab_flags_t next_flags;
  logic writes_file;
  logic writes_acc;
  logic [CAB_DATA_W:0] sum;
  logic [CAB_NIB_MSB+1:0] nib;
  logic cin;
  logic mem_we;
  logic [CAB_ADDR_W-1:0] mem_addr;
  logic two_cycle;

  // Operand fetched one cycle after issue
  assign mem_addr = (state == CAB_ST_IDLE) ? instr_i.addr : cur.addr;
  assign mem_we = (state == CAB_ST_EXEC) ? writes_file : host_we_i;

  cab_file_mem u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i((state == CAB_ST_EXEC) ? cur.addr : host_addr_i),
    .wdata_i((state == CAB_ST_EXEC) ? next_result : host_wdata_i),
    .raddr_i((state == CAB_ST_IDLE && !issue_i) ? host_addr_i : mem_addr),
    .rdata_o(fval)
  );
  assign host_rdata_o = fval;
  assign ready_o = (state == CAB_ST_IDLE);

  always_comb begin
    cin = (cur.op == CAB_OP_ADD_WITH_CARRY_TO_FILE) ? flags_o.carry : 1'b0;
    sum = {1'b0, acc_o} + {1'b0, fval} + {{CAB_DATA_W{1'b0}}, cin};
    nib = {1'b0, acc_o[CAB_NIB_MSB:0]} + {1'b0, fval[CAB_NIB_MSB:0]} + {4'h0, cin};
    next_result = fval;
    next_flags = flags_o;
    writes_file = 1'b0;
    writes_acc = 1'b0;
    two_cycle = 1'b0;
    case (cur.op)
      CAB_OP_ADD_ACC_TO_FILE, CAB_OP_ADD_WITH_CARRY_TO_FILE: begin
        next_result = sum[CAB_DATA_W-1:0];
        next_flags.carry = sum[CAB_DATA_W];
        next_flags.half_carry_flag = nib[CAB_NIB_MSB+1];
        next_flags.zero = (sum[CAB_DATA_W-1:0] == 8'h00);
        writes_file = cur.dest;
        writes_acc = !cur.dest;
      end
      CAB_OP_ARITH_SHIFT_RIGHT_FILE: begin
        next_result = {fval[CAB_DATA_W-1], fval[CAB_DATA_W-1:1]};
        next_flags.carry = fval[0];
        next_flags.zero = ({fval[CAB_DATA_W-1], fval[CAB_DATA_W-1:1]} == 8'h00);
        writes_file = cur.dest;
        writes_acc = !cur.dest;
      end
      CAB_OP_CLEAR_FILE_BIT: begin
        next_result = fval & ~(8'h01 << cur.bit_sel);
        writes_file = 1'b1;
      end
      CAB_OP_TEST_BIT_SKIP_IF_ZERO: begin
        two_cycle = !fval[cur.bit_sel];
      end
      CAB_OP_RELATIVE_JUMP: begin
        two_cycle = 1'b1;
      end
      default: begin
        two_cycle = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      CAB_ST_IDLE: begin
        if (issue_i) begin
          next_state = CAB_ST_EXEC;
        end
      end
      CAB_ST_EXEC: begin
        next_state = two_cycle ? CAB_ST_NOP : CAB_ST_IDLE;
      end
      CAB_ST_NOP: begin
        next_state = CAB_ST_IDLE;
      end
      default: begin
        next_state = CAB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= CAB_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= '0;
    end else if (state == CAB_ST_IDLE && issue_i) begin
      cur <= instr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_o <= CAB_ACC_RESET;
      flags_o <= '0;
    end else if (state == CAB_ST_EXEC) begin
      flags_o <= next_flags;
      if (writes_acc) begin
        acc_o <= next_result;
      end
    end
  end

  // Program counter: +1 per instruction, jump adds sign-extended offset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pc_o <= CAB_PC_RESET;
    end else if (state == CAB_ST_EXEC) begin
      if (cur.op == CAB_OP_RELATIVE_JUMP) begin
        pc_o <= pc_o + 15'h0001 + {{(CAB_PC_W-CAB_OFS_W){cur.offset[CAB_OFS_W-1]}}, cur.offset};
      end else begin
        pc_o <= pc_o + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      nop_cycle_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      nop_cycle_o <= (state == CAB_ST_EXEC) && two_cycle;
      done_o <= (state == CAB_ST_EXEC && !two_cycle) || (state == CAB_ST_NOP);
    end
  end

  jump_target_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_RELATIVE_JUMP |=> pc_o == $past(pc_o) + 15'h0001
      + {{6{$past(cur.offset[8])}}, $past(cur.offset)}) else $error("jump target wrong");
  jump_two_cycles_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_RELATIVE_JUMP |=> nop_cycle_o ##1 done_o)
    else $error("jump not two cycles");
  jump_flags_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_RELATIVE_JUMP |=> $stable(flags_o))
    else $error("jump altered flags");
  skip_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_TEST_BIT_SKIP_IF_ZERO |->
    ##1 (nop_cycle_o == !$past(fval[cur.bit_sel]))) else $error("skip wrong");
  clear_bit_flags_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_CLEAR_FILE_BIT |=> $stable(flags_o)
    && $stable(acc_o)) else $error("bit clear touched state");
  add_flags_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_ADD_ACC_TO_FILE |=>
    flags_o.carry == $past(sum[8]) && flags_o.zero == ($past(sum[7:0]) == 8'h00))
    else $error("add flags wrong");
  dest_acc_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op != CAB_OP_CLEAR_FILE_BIT && cur.dest |=> $stable(acc_o))
    else $error("acc written with dest set");
  shift_carry_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_ARITH_SHIFT_RIGHT_FILE |=>
    flags_o.carry == $past(fval[0])) else $error("shift carry wrong");
  nop_next_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_NOP |=> state == CAB_ST_IDLE) else $error("no-op too long");
  addc_half_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_ADD_WITH_CARRY_TO_FILE |=>
    flags_o.half_carry_flag == ($past({1'b0, acc_o[3:0]} + {1'b0, fval[3:0]}
      + {4'h0, flags_o.carry}) > 5'h0f))
    else $error("add with carry half carry wrong");
  addc_result_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_ADD_WITH_CARRY_TO_FILE && !cur.dest |=>
    acc_o == $past(acc_o + fval + {7'h00, flags_o.carry}))
    else $error("add with carry result wrong");
  shift_result_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state == CAB_ST_EXEC && cur.op == CAB_OP_ARITH_SHIFT_RIGHT_FILE && !cur.dest |=>
    acc_o == $past({fval[7], fval[7:1]}) && flags_o.zero == (acc_o == 8'h00))
    else $error("shift result wrong");
  done_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
    done_o |=> !done_o) else $error("done longer than one cycle");

  jump_c: cover property (@(posedge clk_i) state == CAB_ST_EXEC && cur.op == CAB_OP_RELATIVE_JUMP);
  skip_c: cover property (@(posedge clk_i) nop_cycle_o && cur.op == CAB_OP_TEST_BIT_SKIP_IF_ZERO);
  addc_c: cover property (@(posedge clk_i) state == CAB_ST_EXEC
    && cur.op == CAB_OP_ADD_WITH_CARRY_TO_FILE && flags_o.carry);
  shift_c: cover property (@(posedge clk_i) state == CAB_ST_EXEC
    && cur.op == CAB_OP_ARITH_SHIFT_RIGHT_FILE && fval[0]);
endmodule : cab_exec

// ==== hdl/cab_file_mem.sv ====
// Data memory file with registered read port
module cab_file_mem
  import cab_pkg::*;
#(
  parameter int DATA_W = CAB_DATA_W,
  parameter int ADDR_W = CAB_ADDR_W
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  // Read port
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule : cab_file_mem

// ==== hdl/cab_pkg.sv ====
// Package for the arithmetic, bit and branch execution block
package cab_pkg;
  localparam int CAB_DATA_W = 8;
  localparam int CAB_ADDR_W = 7;
  localparam int CAB_PC_W = 15;
  localparam int CAB_OFS_W = 9;
  localparam int CAB_BIT_W = 3;
  localparam int CAB_NIB_MSB = 3;
  localparam logic [CAB_PC_W-1:0] CAB_PC_RESET = 15'h0000;
  localparam logic [CAB_DATA_W-1:0] CAB_ACC_RESET = 8'h00;

  typedef enum logic [2:0] {
    CAB_OP_NOP,
    CAB_OP_ADD_ACC_TO_FILE,
    CAB_OP_ADD_WITH_CARRY_TO_FILE,
    CAB_OP_ARITH_SHIFT_RIGHT_FILE,
    CAB_OP_CLEAR_FILE_BIT,
    CAB_OP_TEST_BIT_SKIP_IF_ZERO,
    CAB_OP_RELATIVE_JUMP
  } cab_op_t;

  typedef struct packed {
    cab_op_t op;
    logic [CAB_ADDR_W-1:0] addr;
    logic dest;
    logic [CAB_BIT_W-1:0] bit_sel;
    logic [CAB_OFS_W-1:0] offset;
  } cab_instr_t;

  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } cab_flags_t;
endpackage : cab_pkg

// ==== sim/cab_exec_bench.sv ====
// Self-checking bench for the execution unit, compared with an integer model
module cab_exec_bench;
  import cab_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic issue_i = 1'b0;
  cab_instr_t instr_i = '0;
  logic host_we_i = 1'b0;
  logic [CAB_ADDR_W-1:0] host_addr_i = '0;
  logic [CAB_DATA_W-1:0] host_wdata_i = '0;
  logic ready_o;
  logic [CAB_DATA_W-1:0] acc_o;
  cab_flags_t flags_o;
  logic [CAB_PC_W-1:0] pc_o;
  logic nop_cycle_o;
  logic done_o;
  logic [CAB_DATA_W-1:0] host_rdata_o;
  int fail_count = 0;
  int checks = 0;
  int m_acc = 0;
  int m_pc = 0;
  int m_c = 0;
  int m_hc = 0;
  int m_z = 0;
  int mem [128];

  cab_exec dut_u (.clk_i(clk_i), .reset_i(reset_i), .issue_i(issue_i), .instr_i(instr_i),
    .ready_o(ready_o), .acc_o(acc_o), .flags_o(flags_o), .pc_o(pc_o),
    .nop_cycle_o(nop_cycle_o), .done_o(done_o), .host_we_i(host_we_i),
    .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o));

  always #2.5 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic wr(input int a, input int v);
    @(posedge clk_i);
    host_we_i <= 1'b1;
    host_addr_i <= a[6:0];
    host_wdata_i <= v[7:0];
    mem[a] = v & 255;
    @(posedge clk_i);
    host_we_i <= 1'b0;
  endtask : wr

  task automatic run(input cab_op_t op, input int a, input int d, input int b, input int off);
    cab_instr_t ins;
    int f, r, n, nop, two, cin;
    ins = '{op, a[6:0], d[0], b[2:0], off[8:0]};
    f = mem[a];
    r = f;
    two = 0;
    cin = (op == CAB_OP_ADD_WITH_CARRY_TO_FILE) ? m_c : 0;
    case (op)
      CAB_OP_ADD_ACC_TO_FILE, CAB_OP_ADD_WITH_CARRY_TO_FILE: begin
        r = m_acc + f + cin;
        m_hc = ((m_acc & 15) + (f & 15) + cin) > 15;
        m_c = r > 255;
        r = r & 255;
        m_z = r == 0;
      end
      CAB_OP_ARITH_SHIFT_RIGHT_FILE: begin
        r = (f & 128) | (f >> 1);
        m_c = f & 1;
        m_z = r == 0;
      end
      CAB_OP_CLEAR_FILE_BIT: mem[a] = f & ~(1 << b);
      CAB_OP_TEST_BIT_SKIP_IF_ZERO: two = ((f >> b) & 1) == 0;
      default: two = 1;
    endcase
    if (op inside {CAB_OP_ADD_ACC_TO_FILE, CAB_OP_ADD_WITH_CARRY_TO_FILE,
                   CAB_OP_ARITH_SHIFT_RIGHT_FILE}) begin
      if (d != 0) mem[a] = r;
      else m_acc = r;
    end
    m_pc = (m_pc + 1 + ((op == CAB_OP_RELATIVE_JUMP) ? off : 0)) & 32'h7fff;
    @(posedge clk_i);
    issue_i <= 1'b1;
    instr_i <= ins;
    @(posedge clk_i);
    issue_i <= 1'b0;
    n = 0;
    nop = 0;
    while (n < 20) begin
      @(negedge clk_i);
      n++;
      if (nop_cycle_o === 1'b1) nop = 1;
      if (done_o === 1'b1) break;
    end
    check(n, two ? 3 : 2);
    check(ready_o, 1);
    check(nop, two);
    check(acc_o, m_acc);
    check(flags_o, {m_c[0], m_hc[0], m_z[0]});
    check(pc_o, m_pc);
    @(posedge clk_i);
    host_addr_i <= a[6:0];
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check(host_rdata_o, mem[a]);
  endtask : run

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    void'($urandom(32'hbe5b));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check({acc_o, pc_o, flags_o}, 0);
    for (int i = 0; i < 128; i++) wr(i, $urandom_range(0, 255));
    // Carry and half carry boundaries, then shift, bit and jump edge cases
    wr(1, 8'h0f);
    wr(2, 8'h01);
    wr(3, 8'h80);
    run(CAB_OP_ADD_ACC_TO_FILE, 1, 0, 0, 0);
    run(CAB_OP_ADD_ACC_TO_FILE, 2, 0, 0, 0);
    run(CAB_OP_ADD_ACC_TO_FILE, 3, 0, 0, 0);
    run(CAB_OP_ADD_ACC_TO_FILE, 3, 1, 0, 0);
    run(CAB_OP_ADD_WITH_CARRY_TO_FILE, 3, 1, 0, 0);
    run(CAB_OP_ARITH_SHIFT_RIGHT_FILE, 3, 1, 0, 0);
    for (int b = 0; b < 8; b++) begin
      wr(4, 8'h5a);
      run(CAB_OP_TEST_BIT_SKIP_IF_ZERO, 4, 0, b, 0);
      run(CAB_OP_CLEAR_FILE_BIT, 4, 0, b, 0);
    end
    run(CAB_OP_RELATIVE_JUMP, 0, 0, 0, -256);
    run(CAB_OP_RELATIVE_JUMP, 0, 0, 0, 255);
    $display("test directed done");
    for (int i = 0; i < 400; i++) begin
      run(cab_op_t'($urandom_range(1, 6)), $urandom_range(0, 127), $urandom_range(0, 1),
          $urandom_range(0, 7), int'($urandom_range(0, 511)) - 256);
    end
    $display("test random done");
    final_report();
  end
endmodule : cab_exec_bench
